// file: agu_top.sv
// Purpose: Address generation datapath with pointers, stack pointer, offset and modifier.
// Assumes: The issuer holds an instruction while stall is high and obeys the stack pointer spacing.
// Notes: Register writes travel with the instruction word; reads use a separate bus port.
// How it works
// - Modulo unit and incrementer give two addresses and two updates per dual read.
// - Primary data and program address buses carry full 16-bit addresses.
// - Secondary address bus carries 16 bits but only reaches on-chip memory.
// - Primary operand on primary bus to global bus; second on secondary bus.
// - Offset works with every pointer; modifier applies to pointer 0, optionally 1.
// - All unit registers read and written over the core global data bus.
// - Four 16-bit pointers feed and are loaded from the modulo unit.
// - Pointer 3 also updates through the incrementer during dual reads.
// - Moved or bit-field pointer, stack, modifier values take effect two instructions later.
// - Stack pointer serves push and pop, decrements on pop, usable indirectly.
// - Move to offset stretches one cycle when the next instruction uses it.
// - Move to offset without a following user completes without a stretch.
// - Bit-field write of offset never stalls and lands two instructions later.
// - Present original pointer then post-update it; or drive a computed address.
// - Drive and post-update program addresses; step normalization counter; conditional move.
// - Indirect forms: none, inc, dec, post offset, index offset, 16-bit, 6-bit.
// - Program bus stays free for the instruction fetch during data accesses.
// - Modifier resets to all ones, selecting linear arithmetic.
// - Modulo update wraps pointer plus step modulo modifier plus one.
// - The pointer 3 incrementer does linear arithmetic only.
`timescale 1ns/1ns
module agu_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire agu_pkg::agu_instr_type instr,
    input wire logic modifier_covers_ptr1,
    input wire logic core_global_data_bus_rd_en,
    input wire logic [2:0] core_global_data_bus_rd_sel,
    output logic [15:0] core_global_data_bus_rd_data,
    output logic [15:0] primary_data_address_bus,
    output logic primary_addr_valid,
    output logic [15:0] secondary_data_address_bus,
    output logic secondary_addr_valid,
    output logic [15:0] program_address_bus,
    output logic program_addr_valid,
    output logic stall
);

    logic [15:0] regs [0:agu_pkg::REG_COUNT-1];
    agu_pkg::agu_state_type state;
    agu_pkg::agu_state_type next_state;
    logic pend_valid;
    logic [2:0] pend_sel;
    logic [15:0] pend_data;

    logic take;
    logic [15:0] src;
    logic [15:0] idx_addr;
    logic [15:0] xaddr;
    logic [15:0] step;
    logic is_index;
    logic upd_en;
    logic mod_en;
    logic [2:0] upd_sel;
    logic [15:0] upd_base;
    logic [15:0] mod_result;
    logic [15:0] incdec_result;
    logic move_offset;
    logic to_pending;

    function automatic logic [15:0] agu_reg_read(input logic [2:0] sel, input logic [15:0] r0, input logic [15:0] r1,
                                                 input logic [15:0] r2, input logic [15:0] r3, input logic [15:0] rs,
                                                 input logic [15:0] ro, input logic [15:0] rm);
        case (sel)
            agu_pkg::REG_PTR0: return r0;
            agu_pkg::REG_PTR1: return r1;
            agu_pkg::REG_PTR2: return r2;
            agu_pkg::REG_PTR3: return r3;
            agu_pkg::REG_STACK_PTR: return rs;
            agu_pkg::REG_OFFSET: return ro;
            agu_pkg::REG_MODIFIER: return rm;
            default: return 16'h0000;
        endcase
    endfunction

    assign take = instr_valid && (state == agu_pkg::ST_RUN);

    always_comb begin
        upd_sel = instr.ptr_sel;
        if ((instr.op == agu_pkg::OP_PUSH) || (instr.op == agu_pkg::OP_POP)) begin
            upd_sel = agu_pkg::REG_STACK_PTR;
        end
        src = agu_reg_read(upd_sel, regs[0], regs[1], regs[2], regs[3], regs[4], regs[5], regs[6]);
        upd_base = src;
        is_index = 1'b0;
        idx_addr = src;
        case (instr.mode)
            agu_pkg::MODE_INDEX_OFFSET: begin
                is_index = 1'b1;
                idx_addr = 16'(src + regs[agu_pkg::REG_OFFSET]);
            end
            agu_pkg::MODE_INDEX_LONG: begin
                is_index = 1'b1;
                idx_addr = 16'(src + instr.imm);
            end
            agu_pkg::MODE_INDEX_SHORT: begin
                is_index = 1'b1;
                idx_addr = 16'(src + {{10{instr.imm[agu_pkg::SHORT_INDEX_MSB]}}, instr.imm[5:0]});
            end
            default: begin
                idx_addr = src;
            end
        endcase
        xaddr = is_index ? idx_addr : src;
        step = 16'h0000;
        upd_en = 1'b0;
        case (instr.mode)
            agu_pkg::MODE_POST_INC: begin
                step = agu_pkg::STEP_PLUS_ONE;
                upd_en = 1'b1;
            end
            agu_pkg::MODE_POST_DEC: begin
                step = agu_pkg::STEP_MINUS_ONE;
                upd_en = 1'b1;
            end
            agu_pkg::MODE_POST_OFFSET: begin
                step = regs[agu_pkg::REG_OFFSET];
                upd_en = 1'b1;
            end
            default: begin
                step = 16'h0000;
            end
        endcase
        case (instr.op)
            agu_pkg::OP_XMEM, agu_pkg::OP_DUAL_READ, agu_pkg::OP_PMEM, agu_pkg::OP_NORM_STEP: begin
                upd_en = upd_en;
            end
            agu_pkg::OP_PUSH: begin
                step = agu_pkg::STEP_PLUS_ONE;
                upd_en = 1'b1;
            end
            agu_pkg::OP_POP: begin
                step = agu_pkg::STEP_MINUS_ONE;
                upd_en = 1'b1;
            end
            default: begin
                upd_en = 1'b0;
            end
        endcase
        // Only pointer 0, and pointer 1 when enabled, see the modifier.
        mod_en = (upd_sel == agu_pkg::REG_PTR0) || ((upd_sel == agu_pkg::REG_PTR1) && modifier_covers_ptr1);
        move_offset = instr.wr_en && !instr.wr_bitfield && (instr.wr_sel == agu_pkg::REG_OFFSET);
        to_pending = instr.wr_en && !move_offset && (instr.wr_sel < 3'(agu_pkg::REG_COUNT));
    end

    agu_modulo_unit u_agu_modulo_unit (
        .ptr(upd_base),
        .step(step),
        .modifier(regs[agu_pkg::REG_MODIFIER]),
        .modulo_en(mod_en),
        .result(mod_result)
    );

    agu_incdec_unit u_agu_incdec_unit (
        .ptr(regs[agu_pkg::REG_PTR3]),
        .dec(instr.ptr3_dec),
        .result(incdec_result)
    );

    // Later assignments win: a delayed bus write overrides an update of the same register in that cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs[0] <= agu_pkg::PTR_RESET;
            regs[1] <= agu_pkg::PTR_RESET;
            regs[2] <= agu_pkg::PTR_RESET;
            regs[3] <= agu_pkg::PTR_RESET;
            regs[4] <= agu_pkg::STACK_PTR_RESET;
            regs[5] <= agu_pkg::OFFSET_RESET;
            regs[6] <= agu_pkg::MODIFIER_RESET;
        end else if (take) begin
            if (upd_en) begin
                regs[upd_sel] <= mod_result;
            end
            if (instr.op == agu_pkg::OP_EFF_ADDR_LOAD) begin
                regs[instr.ptr_sel] <= is_index ? idx_addr : mod_result;
            end
            if (instr.op == agu_pkg::OP_DUAL_READ) begin
                regs[agu_pkg::REG_PTR3] <= incdec_result;
            end
            if ((instr.op == agu_pkg::OP_COND_MOVE) && instr.cond_true && (instr.cond_dst < 3'(agu_pkg::REG_COUNT))) begin
                regs[instr.cond_dst] <= src;
            end
            if (pend_valid) begin
                regs[pend_sel] <= pend_data;
            end
            if (move_offset) begin
                regs[agu_pkg::REG_OFFSET] <= instr.wr_data;
            end
        end
    end

    // Bus writes other than a move into the offset wait for the next instruction before landing.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_sel <= 3'h0;
            pend_data <= 16'h0000;
        end else if (take) begin
            pend_valid <= to_pending;
            pend_sel <= instr.wr_sel;
            pend_data <= instr.wr_data;
        end
    end

    always_comb begin
        next_state = agu_pkg::ST_RUN;
        case (state)
            agu_pkg::ST_RUN: begin
                if (take && move_offset && instr.next_uses_offset) begin
                    next_state = agu_pkg::ST_STRETCH;
                end else begin
                    next_state = agu_pkg::ST_RUN;
                end
            end
            agu_pkg::ST_STRETCH: begin
                next_state = agu_pkg::ST_RUN;
            end
            default: begin
                next_state = agu_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= agu_pkg::ST_RUN;
            stall <= 1'b0;
        end else begin
            state <= next_state;
            stall <= (next_state == agu_pkg::ST_STRETCH);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_data_address_bus <= 16'h0000;
            primary_addr_valid <= 1'b0;
            secondary_data_address_bus <= 16'h0000;
            secondary_addr_valid <= 1'b0;
            program_address_bus <= 16'h0000;
            program_addr_valid <= 1'b0;
        end else begin
            primary_addr_valid <= 1'b0;
            secondary_addr_valid <= 1'b0;
            program_addr_valid <= 1'b0;
            if (take) begin
                case (instr.op)
                    agu_pkg::OP_XMEM, agu_pkg::OP_POP: begin
                        primary_data_address_bus <= xaddr;
                        primary_addr_valid <= 1'b1;
                    end
                    agu_pkg::OP_PUSH: begin
                        primary_data_address_bus <= mod_result;
                        primary_addr_valid <= 1'b1;
                    end
                    agu_pkg::OP_DUAL_READ: begin
                        // Primary operand returns on the global bus, the second on the second data bus.
                        primary_data_address_bus <= xaddr;
                        primary_addr_valid <= 1'b1;
                        // No on-chip check here; the issuer keeps this read on-chip.
                        secondary_data_address_bus <= regs[agu_pkg::REG_PTR3];
                        secondary_addr_valid <= 1'b1;
                    end
                    agu_pkg::OP_PMEM: begin
                        program_address_bus <= xaddr;
                        program_addr_valid <= 1'b1;
                    end
                    default: begin
                        // Data accesses leave the program bus to the fetch logic.
                        program_addr_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_global_data_bus_rd_data <= 16'h0000;
        end else if (core_global_data_bus_rd_en) begin
            core_global_data_bus_rd_data <= agu_reg_read(core_global_data_bus_rd_sel, regs[0], regs[1], regs[2],
                                                         regs[3], regs[4], regs[5], regs[6]);
        end
    end

    a_modifier_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> (regs[agu_pkg::REG_MODIFIER] == agu_pkg::MODIFIER_RESET))
        else $error("modifier not all ones after reset");

    a_pending_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && pend_valid && !move_offset) |=> (regs[$past(pend_sel)] == $past(pend_data)))
        else $error("delayed register write did not land");

    a_pending_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && to_pending) |=> pend_valid && (pend_data == $past(instr.wr_data)))
        else $error("register write not held back one instruction");

    a_offset_stretch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && move_offset && instr.next_uses_offset) |=> stall ##1 !stall)
        else $error("offset move not stretched by exactly one cycle");

    a_offset_no_stretch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && move_offset && !instr.next_uses_offset) |=> !stall)
        else $error("offset move stretched without a user");

    // An earlier bit-field write of the offset may land at this edge; only this one must wait.
    a_bitfield_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && instr.wr_en && instr.wr_bitfield && (instr.wr_sel == agu_pkg::REG_OFFSET))
        |=> !stall && (regs[agu_pkg::REG_OFFSET] == $past(regs[agu_pkg::REG_OFFSET]) || $past(upd_en)
        || ($past(pend_valid) && ($past(pend_sel) == agu_pkg::REG_OFFSET))))
        else $error("bit-field offset write stalled or landed early");

    a_pop_decrements: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && (instr.op == agu_pkg::OP_POP) && !pend_valid)
        |=> primary_addr_valid && (primary_data_address_bus == $past(src))
        && (regs[agu_pkg::REG_STACK_PTR] == 16'($past(src) - 16'h0001)))
        else $error("pop did not use and decrement the stack pointer");

    a_dual_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && (instr.op == agu_pkg::OP_DUAL_READ) && !pend_valid && (instr.ptr_sel != agu_pkg::REG_PTR3))
        |=> secondary_addr_valid && primary_addr_valid
        && (secondary_data_address_bus == $past(regs[agu_pkg::REG_PTR3]))
        && (regs[agu_pkg::REG_PTR3] == 16'($past(regs[agu_pkg::REG_PTR3]) + ($past(instr.ptr3_dec) ? 16'hFFFF : 16'h0001))))
        else $error("dual read second address or pointer 3 step wrong");

    a_linear_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regs[agu_pkg::REG_MODIFIER] == agu_pkg::MODIFIER_RESET) |-> (mod_result == 16'(upd_base + step)))
        else $error("all-ones modifier did not give linear update");

    a_program_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take && (instr.op == agu_pkg::OP_PMEM)) |=> program_addr_valid && !primary_addr_valid
        && (program_address_bus == $past(xaddr)))
        else $error("program memory address not driven");

endmodule

// file: agu_pkg.sv
// Purpose: Shared constants and types of the address generation unit.
// Assumes: 16-bit data and address paths on a single core clock.
// Notes: Register indices select the internal register file and the bus read port.
package agu_pkg;

    localparam int ADDR_W = 16;

    // Register file indices; pointers first so a pointer select is its own index.
    localparam logic [2:0] REG_PTR0 = 3'h0;
    localparam logic [2:0] REG_PTR1 = 3'h1;
    localparam logic [2:0] REG_PTR2 = 3'h2;
    localparam logic [2:0] REG_PTR3 = 3'h3;
    localparam logic [2:0] REG_STACK_PTR = 3'h4;
    localparam logic [2:0] REG_OFFSET = 3'h5;
    localparam logic [2:0] REG_MODIFIER = 3'h6;
    localparam int REG_COUNT = 7;

    // Reset values.
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] STACK_PTR_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] MODIFIER_RESET = 16'hFFFF;

    // Modifier values from this one upward select linear arithmetic.
    localparam logic [15:0] MODIFIER_LINEAR_MIN = 16'h8000;

    // Fixed steps of the update units.
    localparam logic [15:0] STEP_PLUS_ONE = 16'h0001;
    localparam logic [15:0] STEP_MINUS_ONE = 16'hFFFF;

    // Sign position of the short index field.
    localparam int SHORT_INDEX_MSB = 5;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_XMEM = 4'h1,
        OP_DUAL_READ = 4'h2,
        OP_PMEM = 4'h3,
        OP_EFF_ADDR_LOAD = 4'h4,
        OP_PUSH = 4'h5,
        OP_POP = 4'h6,
        OP_NORM_STEP = 4'h7,
        OP_COND_MOVE = 4'h8
    } agu_op_type;

    typedef enum logic [2:0] {
        MODE_NO_UPDATE = 3'h0,
        MODE_POST_INC = 3'h1,
        MODE_POST_DEC = 3'h2,
        MODE_POST_OFFSET = 3'h3,
        MODE_INDEX_OFFSET = 3'h4,
        MODE_INDEX_LONG = 3'h5,
        MODE_INDEX_SHORT = 3'h6
    } agu_mode_type;

    typedef enum logic {
        ST_RUN = 1'b0,
        ST_STRETCH = 1'b1
    } agu_state_type;

    typedef struct packed {
        agu_op_type op;
        logic [2:0] ptr_sel;
        agu_mode_type mode;
        logic ptr3_dec;
        logic [15:0] imm;
        logic wr_en;
        logic wr_bitfield;
        logic [2:0] wr_sel;
        logic [15:0] wr_data;
        logic next_uses_offset;
        logic cond_true;
        logic [2:0] cond_dst;
    } agu_instr_type;

endpackage

// file: agu_modulo_unit.sv
// Purpose: Linear and modulo pointer update arithmetic.
// Assumes: The step magnitude does not exceed the modulus.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module agu_modulo_unit (
    input wire logic [15:0] ptr,
    input wire logic [15:0] step,
    input wire logic [15:0] modifier,
    input wire logic modulo_en,
    output logic [15:0] result
);

    function automatic logic [15:0] agu_fill_ones(input logic [15:0] m);
        logic [15:0] f;
        f = m | (m >> 1);
        f = f | (f >> 2);
        f = f | (f >> 4);
        f = f | (f >> 8);
        return f;
    endfunction

    logic [15:0] mask;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] modulus;
    logic signed [17:0] sum;

    always_comb begin
        mask = agu_fill_ones(modifier);
        lower = ptr & ~mask;
        upper = lower | modifier;
        modulus = 16'(modifier + agu_pkg::STEP_PLUS_ONE);
        sum = $signed({2'h0, ptr}) + $signed({{2{step[15]}}, step});
        result = sum[15:0];
        // The buffer base is the pointer with its low bits cleared, so the buffer must be aligned.
        if (modulo_en && (modifier < agu_pkg::MODIFIER_LINEAR_MIN)) begin
            if (sum > $signed({2'h0, upper})) begin
                result = 16'(sum[15:0] - modulus);
            end else if (sum < $signed({2'h0, lower})) begin
                result = 16'(sum[15:0] + modulus);
            end
        end
    end

endmodule

// file: agu_incdec_unit.sv
// Purpose: Independent increment or decrement of the fourth pointer.
// Assumes: Used only for the second read of a dual read.
// Notes: Linear only; the modifier never reaches this path.
`timescale 1ns/1ns
module agu_incdec_unit (
    input wire logic [15:0] ptr,
    input wire logic dec,
    output logic [15:0] result
);

    always_comb begin
        result = dec ? 16'(ptr + agu_pkg::STEP_MINUS_ONE) : 16'(ptr + agu_pkg::STEP_PLUS_ONE);
    end

endmodule

// file: agu_mem_model.sv
// Purpose: Far-side data memory model watching the secondary address bus.
// Assumes: On-chip data memory spans the addresses below ONCHIP_TOP.
// Notes: Flags any second-read address that would leave on-chip memory.
`timescale 1ns/1ns
module agu_mem_model #(
    parameter logic [15:0] ONCHIP_TOP = 16'h0800
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] secondary_data_address_bus,
    input wire logic secondary_addr_valid,
    output logic offchip_seen
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            offchip_seen <= 1'b0;
        end else if (secondary_addr_valid && secondary_data_address_bus >= ONCHIP_TOP) begin
            offchip_seen <= 1'b1;
        end
    end
endmodule

// file: agu_top_bench.sv
// Purpose: Self-checking bench for the address generation unit.
// Assumes: Stall is registered at the edge that takes an offset move.
// Notes: Inputs change on the falling edge; results are read at the next falling edge.
`timescale 1ns/1ns
module agu_top_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    agu_pkg::agu_instr_type instr = '0;
    logic covers = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] rd_sel = 3'h0;
    logic [15:0] rd_data, pa, sa, pg, b, ea, nb, idx;
    logic pv, sv, gv, stall, offchip;
    agu_pkg::agu_instr_type t;
    int miscompares = 0;
    int num_checks = 0;
    int stalls = 0;
    int s0, k;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (stall === 1'b1) stalls++;
    end
    agu_top u_agu_top (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .modifier_covers_ptr1(covers), .core_global_data_bus_rd_en(rd_en), .core_global_data_bus_rd_sel(rd_sel),
        .core_global_data_bus_rd_data(rd_data), .primary_data_address_bus(pa), .primary_addr_valid(pv),
        .secondary_data_address_bus(sa), .secondary_addr_valid(sv), .program_address_bus(pg),
        .program_addr_valid(gv), .stall(stall));
    agu_mem_model u_agu_mem_model (.sys_clk(sys_clk), .rst_n(rst_n), .secondary_data_address_bus(sa),
        .secondary_addr_valid(sv), .offchip_seen(offchip));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic agu_pkg::agu_instr_type mk(input agu_pkg::agu_op_type o, input logic [2:0] p,
                                                  input agu_pkg::agu_mode_type m, input logic [15:0] imm);
        agu_pkg::agu_instr_type i;
        i = '0;
        i.op = o;
        i.ptr_sel = p;
        i.mode = m;
        i.imm = imm;
        return i;
    endfunction
    // A refused instruction is held until stall drops, as the issuer must.
    task automatic issue(input agu_pkg::agu_instr_type i);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr = i;
        while (stall !== 1'b0) @(negedge sys_clk);
        @(negedge sys_clk);
        instr_valid = 1'b0;
    endtask
    task automatic xm(input logic [2:0] p, input agu_pkg::agu_mode_type m);
        issue(mk(agu_pkg::OP_XMEM, p, m, 16'h0000));
    endtask
    task automatic wrt(input logic [2:0] s, input logic [15:0] d, input logic bf, input logic nu);
        agu_pkg::agu_instr_type i;
        i = mk(agu_pkg::OP_NONE, 3'h0, agu_pkg::MODE_NO_UPDATE, 16'h0000);
        i.wr_en = 1'b1;
        i.wr_sel = s;
        i.wr_data = d;
        i.wr_bitfield = bf;
        i.next_uses_offset = nu;
        issue(i);
    endtask
    task automatic rd(input logic [2:0] s, input logic [15:0] exp);
        @(negedge sys_clk);
        rd_en = 1'b1;
        rd_sel = s;
        @(negedge sys_clk);
        rd_en = 1'b0;
        chk(rd_data, exp);
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        for (k = 0; k < 7; k++) rd(k[2:0], (k == 6) ? 16'hFFFF : 16'h0000);
        for (k = 0; k < 6; k++) wrt(k[2:0], 16'((k + 1) << 8), 1'b0, 1'b0);
        issue(mk(agu_pkg::OP_NONE, 3'h0, agu_pkg::MODE_NO_UPDATE, 16'h0000));
        for (k = 0; k < 6; k++) rd(k[2:0], 16'((k + 1) << 8));
        chk(16'(stalls), 16'h0000);
        wrt(3'h2, 16'h0777, 1'b0, 1'b0);
        xm(3'h2, agu_pkg::MODE_NO_UPDATE);
        chk(pa, 16'h0300);
        xm(3'h2, agu_pkg::MODE_NO_UPDATE);
        chk(pa, 16'h0777);
        b = 16'h0200;
        for (k = 0; k < 7; k++) begin
            idx = (k == 4) ? 16'h0600 : (k == 5) ? 16'hAB3E : 16'hFFFE;
            ea = (k >= 4) ? b + idx : b;
            nb = (k == 1) ? b + 1 : (k == 2) ? b - 1 : (k == 3) ? b + 16'h0600 : b;
            issue(mk(agu_pkg::OP_XMEM, 3'h1, agu_pkg::agu_mode_type'(k), 16'hAB3E));
            chk(pa, ea);
            chk({15'h0000, pv}, 16'h0001);
            rd(3'h1, nb);
            b = nb;
        end
        t = mk(agu_pkg::OP_DUAL_READ, 3'h1, agu_pkg::MODE_POST_INC, 16'h0000);
        t.ptr3_dec = 1'b1;
        issue(t);
        chk(pa, b);
        chk(sa, 16'h0400);
        chk({15'h0000, sv}, 16'h0001);
        rd(3'h3, 16'h03FF);
        rd(3'h1, b + 16'h0001);
        wrt(3'h6, 16'h0007, 1'b0, 1'b0);
        wrt(3'h0, 16'h0107, 1'b0, 1'b0);
        wrt(3'h1, 16'h020F, 1'b0, 1'b0);
        wrt(3'h3, 16'h0003, 1'b0, 1'b0);
        xm(3'h0, agu_pkg::MODE_POST_INC);
        rd(3'h0, 16'h0100);
        xm(3'h1, agu_pkg::MODE_POST_INC);
        rd(3'h1, 16'h0210);
        covers = 1'b1;
        xm(3'h1, agu_pkg::MODE_POST_DEC);
        rd(3'h1, 16'h0217);
        issue(mk(agu_pkg::OP_DUAL_READ, 3'h2, agu_pkg::MODE_POST_INC, 16'h0000));
        rd(3'h3, 16'h0004);
        rd(3'h2, 16'h0778);
        issue(mk(agu_pkg::OP_PUSH, 3'h0, agu_pkg::MODE_NO_UPDATE, 16'h0000));
        chk(pa, 16'h0501);
        issue(mk(agu_pkg::OP_POP, 3'h0, agu_pkg::MODE_NO_UPDATE, 16'h0000));
        chk(pa, 16'h0501);
        rd(3'h4, 16'h0500);
        issue(mk(agu_pkg::OP_PMEM, 3'h2, agu_pkg::MODE_POST_INC, 16'h0000));
        chk(pg, 16'h0778);
        chk({14'h0000, gv, pv}, 16'h0002);
        rd(3'h2, 16'h0779);
        s0 = stalls;
        t = mk(agu_pkg::OP_NONE, 3'h0, agu_pkg::MODE_NO_UPDATE, 16'h0000);
        t.wr_en = 1'b1;
        t.wr_sel = 3'h5;
        t.wr_data = 16'h0020;
        t.next_uses_offset = 1'b1;
        // The user follows back to back, so it is presented while stall is high and must be refused once.
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr = t;
        @(negedge sys_clk);
        instr = mk(agu_pkg::OP_XMEM, 3'h2, agu_pkg::MODE_POST_OFFSET, 16'h0000);
        chk({15'h0000, stall}, 16'h0001);
        while (stall !== 1'b0) @(negedge sys_clk);
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(pa, 16'h0779);
        rd(3'h2, 16'h0799);
        chk(16'(stalls - s0), 16'h0001);
        wrt(3'h5, 16'h0040, 1'b1, 1'b0);
        xm(3'h2, agu_pkg::MODE_POST_OFFSET);
        xm(3'h2, agu_pkg::MODE_POST_OFFSET);
        rd(3'h2, 16'h07F9);
        chk(16'(stalls - s0), 16'h0001);
        issue(mk(agu_pkg::OP_EFF_ADDR_LOAD, 3'h2, agu_pkg::MODE_INDEX_LONG, 16'h0007));
        rd(3'h2, 16'h0800);
        issue(mk(agu_pkg::OP_NORM_STEP, 3'h2, agu_pkg::MODE_POST_DEC, 16'h0000));
        rd(3'h2, 16'h07FF);
        t = mk(agu_pkg::OP_COND_MOVE, 3'h2, agu_pkg::MODE_NO_UPDATE, 16'h0000);
        t.cond_true = 1'b1;
        issue(t);
        rd(3'h0, 16'h07FF);
        t.cond_true = 1'b0;
        t.cond_dst = 3'h1;
        issue(t);
        rd(3'h1, 16'h0217);
        chk({15'h0000, offchip}, 16'h0000);
        close_out();
    end
endmodule
